// [prs_pkg.sv]
/*
 * Shared constants and types for the pressure sensor target logic: timing
 * figures, strap addresses, command codes, checksum settings and state codes.
 * Assumes a 200 MHz core clock and a serial bus master on the far side.
 */
package prs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int MCLK_KHZ = 200_000;
    localparam int POWER_UP_READY_TIME_MS = 25;
    localparam int SOFT_RESET_READY_TIME_MS = 20;
    localparam int TRIG_MEAS_TIME_MS = 45;
    localparam int UPDATE_RATE_HZ = 2000;
    localparam int SERIAL_CLOCK_RATE_TYP_KHZ = 400;
    localparam int SERIAL_CLOCK_RATE_MAX_KHZ = 1000;
    localparam int PU_CYC = POWER_UP_READY_TIME_MS * MCLK_KHZ;
    localparam int SR_CYC = SOFT_RESET_READY_TIME_MS * MCLK_KHZ;
    localparam int TRIG_CYC = TRIG_MEAS_TIME_MS * MCLK_KHZ;
    localparam int UPD_CYC = (MCLK_KHZ * 1000) / UPDATE_RATE_HZ;
    localparam int TEMP_EVERY = 16;
    localparam int TMR_W = 24;
    localparam int TCNT_W = $clog2(TEMP_EVERY);

    // ****************************************************************
    // Addressing and commands
    // ****************************************************************
    localparam logic [1:0] SEL_GND = 2'h0;
    localparam logic [1:0] SEL_R1K2 = 2'h1;
    localparam logic [1:0] SEL_R2K7 = 2'h2;
    localparam logic [6:0] ADDR_GND = 7'h21;
    localparam logic [6:0] ADDR_R1K2 = 7'h22;
    localparam logic [6:0] ADDR_R2K7 = 7'h23;
    localparam logic [15:0] CMD_CONT_MF_AVG = 16'h3603;
    localparam logic [15:0] CMD_CONT_MF = 16'h3608;
    localparam logic [15:0] CMD_CONT_DP_AVG = 16'h3615;
    localparam logic [15:0] CMD_CONT_DP = 16'h361E;
    localparam logic [15:0] CMD_STOP = 16'h3FF9;
    localparam logic [15:0] CMD_TRIG = 16'h3624;
    localparam logic [15:0] CMD_SOFT_RST = 16'h0006;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [2:0] RD_LAST = 3'h5;

    typedef enum logic [1:0] {
        M_BOOT = 2'b00,
        M_IDLE = 2'b01,
        M_CONT = 2'b10,
        M_TRIG = 2'b11
    } prs_mode_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WR = 3'b011,
        S_WACK = 3'b100,
        S_RD = 3'b101,
        S_RACK = 3'b110
    } prs_bus_e;

endpackage

// [prs_link_if.sv]
/*
 * Link between the serial bit engine and the measurement core.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface prs_link_if;
    logic [6:0] my_addr;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] tx_byte;
    logic rd_hdr;
    logic wr_hdr;
    logic tx_next;
    logic rx_valid;
    logic [7:0] rx_byte;

    modport eng (input my_addr, wr_ok, rd_ok, tx_byte,
                 output rd_hdr, wr_hdr, tx_next, rx_valid, rx_byte);
    modport core (output my_addr, wr_ok, rd_ok, tx_byte,
                  input rd_hdr, wr_hdr, tx_next, rx_valid, rx_byte);
endinterface

// [prs_i2c_target.sv]
/*
 * Serial target bit engine: start/stop detection, address match, byte
 * shifting and acknowledge. Assumes the bus clock is far slower than mclk
 * and that clock stretching is never used.
 */
`timescale 1ns/100ps
module prs_i2c_target
    import prs_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic scl, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_oe, // pull data low while high
    prs_link_if.eng link // to the measurement core
);

    typedef struct packed {
        logic scl1, scl2, scl3;
        logic sda1, sda2, sda3;
        prs_bus_e st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rw;
        logic oe;
        logic rd_hdr, wr_hdr, tx_next, rx_valid;
    } prs_eng_s;

    prs_eng_s r;
    prs_eng_s next_r;
    logic scl_rise, scl_fall, start_c, stop_c;

    // ****************************************************************
    // Bit engine
    // ****************************************************************
    assign scl_rise = r.scl2 & ~r.scl3;
    assign scl_fall = ~r.scl2 & r.scl3;
    assign start_c = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
    assign stop_c = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;

    always_comb begin
        next_r = r;
        next_r.scl1 = scl;
        next_r.scl2 = r.scl1;
        next_r.scl3 = r.scl2;
        next_r.sda1 = sda_i;
        next_r.sda2 = r.sda1;
        next_r.sda3 = r.sda2;
        next_r.rd_hdr = 1'b0;
        next_r.wr_hdr = 1'b0;
        next_r.tx_next = 1'b0;
        next_r.rx_valid = 1'b0;
        if (start_c) begin
            next_r.st = S_ADDR;
            next_r.bits = 4'h0;
            next_r.oe = 1'b0;
        end else if (stop_c) begin
            next_r.st = S_IDLE;
            next_r.oe = 1'b0;
        end else if (scl_rise) begin
            case (r.st)
                S_ADDR, S_WR: begin
                    if (r.bits != 4'h8) begin
                        next_r.sh = {r.sh[6:0], r.sda2};
                        next_r.bits = r.bits + 4'h1;
                    end
                end
                S_RACK: begin
                    // A not-acknowledge from the master ends the read.
                    if (r.sda2) begin
                        next_r.st = S_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (r.st)
                S_ADDR: begin
                    if (r.bits == 4'h8) begin
                        if (r.sh[7:1] == link.my_addr && (r.sh[0] ? link.rd_ok : link.wr_ok)) begin
                            next_r.oe = 1'b1;
                            next_r.rw = r.sh[0];
                            next_r.st = S_AACK;
                            next_r.rd_hdr = r.sh[0];
                            next_r.wr_hdr = ~r.sh[0];
                        end else begin
                            next_r.st = S_IDLE;
                        end
                    end
                end
                S_AACK, S_RACK: begin
                    if (!r.rw) begin
                        next_r.oe = 1'b0;
                        next_r.st = S_WR;
                        next_r.bits = 4'h0;
                    end else begin
                        next_r.sh = link.tx_byte;
                        next_r.oe = ~link.tx_byte[7];
                        next_r.bits = 4'h1;
                        next_r.st = S_RD;
                        next_r.tx_next = 1'b1;
                    end
                end
                S_WR: begin
                    if (r.bits == 4'h8) begin
                        next_r.oe = 1'b1;
                        next_r.rx_valid = 1'b1;
                        next_r.st = S_WACK;
                    end
                end
                S_WACK: begin
                    next_r.oe = 1'b0;
                    next_r.st = S_WR;
                    next_r.bits = 4'h0;
                end
                S_RD: begin
                    if (r.bits == 4'h8) begin
                        next_r.oe = 1'b0;
                        next_r.st = S_RACK;
                    end else begin
                        next_r.sh = {r.sh[6:0], 1'b0};
                        next_r.oe = ~r.sh[6];
                        next_r.bits = r.bits + 4'h1;
                    end
                end
                default: begin
                    next_r.st = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // The synchronisers start at the idle bus level, so no false edge follows reset.
            r <= '0;
            {r.scl1, r.scl2, r.scl3} <= 3'h7;
            {r.sda1, r.sda2, r.sda3} <= 3'h7;
        end else begin
            r <= next_r;
        end
    end

    assign sda_oe = r.oe;
    assign link.rd_hdr = r.rd_hdr;
    assign link.wr_hdr = r.wr_hdr;
    assign link.tx_next = r.tx_next;
    assign link.rx_valid = r.rx_valid;
    assign link.rx_byte = r.sh;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_rd_refused;
        (r.st == S_ADDR && scl_fall && !start_c && !stop_c && r.bits == 4'h8 && r.sh[0]
         && !link.rd_ok) |=> (!r.oe && r.st == S_IDLE);
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("read header acknowledged without data");

    property p_rx_ack;
        r.rx_valid |-> (r.oe && r.st == S_WACK);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("command byte not acknowledged");

    property p_byte_end;
        (r.st == S_RD && scl_fall && !start_c && !stop_c && r.bits == 4'h8)
        |=> (r.st == S_RACK && !r.oe);
    endproperty
    a_byte_end: assert property (p_byte_end) else $error("data not released after eight bits");

endmodule // prs_i2c_target

// [prs_sensor_top.sv]
/*
 * Measurement core of the pressure sensor target: readiness timers,
 * address strap, command decoding, update cadence, result-ready pin and
 * read data with checksums. Assumes sample inputs come from a front end on
 * mclk and the bus master keeps its clock at or below 1000 kHz.
 */
`timescale 1ns/100ps
module prs_sensor_top
    import prs_pkg::*;
#(
    parameter int POWER_UP_CYC = PU_CYC,
    parameter int SOFT_RESET_CYC = SR_CYC,
    parameter int TRIG_MEAS_CYC = TRIG_CYC,
    parameter int UPDATE_CYC = UPD_CYC
) (
    input wire logic mclk, // core clock, 200 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire logic scl, // serial clock from the master
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data drive level, always low
    output logic sda_oe, // serial data pulled low while high
    input wire logic [1:0] addr_sel, // address strap level
    input wire logic [15:0] pres_sample, // pressure from front end
    input wire logic [15:0] temp_sample, // temperature from front end
    output logic result_ready_n // low while an unread result exists, and from any reset until a measurement command
);

    typedef struct packed {
        logic [1:0] sel1, sel2;
        prs_mode_e mode;
        logic [TMR_W-1:0] tmr;
        logic [6:0] addr;
        logic [7:0] cmd_hi;
        logic [1:0] phase;
        logic [TCNT_W-1:0] tcnt;
        logic [15:0] pres, temp, snap_p, snap_t;
        logic have;
        logic rdy_n;
        logic [2:0] idx;
    } prs_core_s;

    prs_core_s r;
    prs_core_s next_r;
    logic tick, new_temp, new_res, soft_exec;
    logic [15:0] cmd_word;
    prs_link_if link ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [6:0] addr_of(input logic [1:0] sel);
        case (sel)
            SEL_R1K2: addr_of = ADDR_R1K2;
            SEL_R2K7: addr_of = ADDR_R2K7;
            default: addr_of = ADDR_GND;
        endcase
    endfunction

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        crc8 = c;
    endfunction

    function automatic logic is_cont(input logic [15:0] c);
        is_cont = (c == CMD_CONT_MF_AVG) || (c == CMD_CONT_MF)
                  || (c == CMD_CONT_DP_AVG) || (c == CMD_CONT_DP);
    endfunction

    prs_i2c_target u_eng (
        .mclk(mclk),
        .rst(rst),
        .scl(scl),
        .sda_i(sda_i),
        .sda_oe(sda_oe),
        .link(link.eng)
    );

    // ****************************************************************
    // Core state
    // ****************************************************************
    assign cmd_word = {r.cmd_hi, link.rx_byte};

    always_comb begin
        next_r = r;
        tick = 1'b0;
        new_temp = 1'b0;
        new_res = 1'b0;
        soft_exec = 1'b0;
        next_r.sel1 = addr_sel;
        next_r.sel2 = r.sel1;
        case (r.mode)
            M_BOOT: begin
                if (r.tmr == '0) begin
                    next_r.mode = M_IDLE;
                    next_r.addr = addr_of(r.sel2);
                end else begin
                    next_r.tmr = r.tmr - 1'b1;
                end
            end
            M_TRIG: begin
                if (r.tmr == '0) begin
                    next_r.mode = M_IDLE;
                    new_res = 1'b1;
                    new_temp = 1'b1;
                end else begin
                    next_r.tmr = r.tmr - 1'b1;
                end
            end
            M_CONT: begin
                if (r.tmr == '0) begin
                    next_r.tmr = TMR_W'(UPDATE_CYC - 1);
                    tick = 1'b1;
                    new_res = 1'b1;
                    new_temp = (r.tcnt == '0);
                    next_r.tcnt = r.tcnt + 1'b1;
                end else begin
                    next_r.tmr = r.tmr - 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (new_res) begin
            next_r.pres = pres_sample;
            next_r.have = 1'b1;
        end
        if (new_temp) begin
            next_r.temp = temp_sample;
        end
        // A fresh result in the same cycle as a read header keeps the pin low.
        if (link.rd_hdr) begin
            next_r.rdy_n = 1'b1;
            next_r.snap_p = r.pres;
            next_r.snap_t = r.temp;
            next_r.idx = 3'h0;
        end
        if (new_res) begin
            next_r.rdy_n = 1'b0;
        end
        if (link.tx_next) begin
            next_r.idx = (r.idx == RD_LAST) ? 3'h0 : r.idx + 3'h1;
        end
        if (link.wr_hdr) begin
            next_r.phase = 2'h0;
        end
        if (link.rx_valid) begin
            if (r.phase == 2'h0) begin
                next_r.cmd_hi = link.rx_byte;
                next_r.phase = 2'h1;
            end else if (r.phase == 2'h1) begin
                next_r.phase = 2'h2;
                if (cmd_word == CMD_SOFT_RST) begin
                    soft_exec = 1'b1;
                    next_r.mode = M_BOOT;
                    next_r.tmr = TMR_W'(SOFT_RESET_CYC - 1);
                    next_r.have = 1'b0;
                    next_r.rdy_n = 1'b0;
                end else if (r.mode == M_IDLE && is_cont(cmd_word)) begin
                    next_r.mode = M_CONT;
                    next_r.tmr = TMR_W'(UPDATE_CYC - 1);
                    next_r.tcnt = '0;
                    next_r.have = 1'b0;
                    next_r.rdy_n = 1'b1;
                end else if (r.mode == M_IDLE && cmd_word == CMD_TRIG) begin
                    next_r.mode = M_TRIG;
                    next_r.tmr = TMR_W'(TRIG_MEAS_CYC - 1);
                    next_r.have = 1'b0;
                    next_r.rdy_n = 1'b1;
                end else if (r.mode == M_CONT && cmd_word == CMD_STOP) begin
                    next_r.mode = M_IDLE;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.mode <= M_BOOT;
            r.tmr <= TMR_W'(POWER_UP_CYC - 1);
            r.addr <= ADDR_GND;
            r.rdy_n <= 1'b0;
            r.idx <= 3'h0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Link and pins
    // ****************************************************************
    assign link.my_addr = r.addr;
    assign link.wr_ok = (r.mode != M_BOOT);
    assign link.rd_ok = r.have && r.mode != M_BOOT && r.mode != M_TRIG;

    always_comb begin
        case (r.idx)
            3'h0: link.tx_byte = r.snap_p[15:8];
            3'h1: link.tx_byte = r.snap_p[7:0];
            3'h2: link.tx_byte = crc8(r.snap_p);
            3'h3: link.tx_byte = r.snap_t[15:8];
            3'h4: link.tx_byte = r.snap_t[7:0];
            default: link.tx_byte = crc8(r.snap_t);
        endcase
    end

    assign result_ready_n = r.rdy_n;
    assign sda_o = 1'b0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [TMR_W-1:0] boot_age, gap;
    logic soft_boot;
    logic [4:0] p_since_t;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_age <= '0;
            gap <= '0;
            soft_boot <= 1'b0;
            p_since_t <= 5'h00;
        end else begin
            boot_age <= (soft_exec || next_r.mode != M_BOOT) ? '0 : boot_age + 1'b1;
            soft_boot <= soft_exec ? 1'b1 : (r.mode == M_BOOT && soft_boot);
            gap <= (tick || r.mode != M_CONT) ? '0 : gap + 1'b1;
            p_since_t <= new_temp ? 5'h00 : (tick ? p_since_t + 5'h01 : p_since_t);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_boot_time;
        (r.mode == M_BOOT && !soft_boot) |-> (boot_age < TMR_W'(POWER_UP_CYC));
    endproperty
    a_boot_time: assert property (p_boot_time) else $error("power-up ready too late");

    property p_soft_time;
        (r.mode == M_BOOT && soft_boot) |-> (boot_age < TMR_W'(SOFT_RESET_CYC));
    endproperty
    a_soft_time: assert property (p_soft_time) else $error("soft reset ready too late");

    property p_rate;
        tick |-> (gap == TMR_W'(UPDATE_CYC - 1));
    endproperty
    a_rate: assert property (p_rate) else $error("pressure update period wrong");

    property p_temp;
        (r.mode == M_CONT) |-> (p_since_t < 5'(TEMP_EVERY));
    endproperty
    a_temp: assert property (p_temp) else $error("temperature update overdue");

    property p_addr;
        (r.mode != M_BOOT && $past(r.mode) != M_BOOT) |-> ($stable(r.addr)
            && (r.addr == ADDR_GND || r.addr == ADDR_R1K2 || r.addr == ADDR_R2K7));
    endproperty
    a_addr: assert property (p_addr) else $error("target address changed or invalid");

    property p_ready_low;
        (new_res && !soft_exec) |=> (!result_ready_n && r.have);
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("result-ready not low on new result");

    property p_clear_on_read;
        (link.rd_hdr && !new_res && !(link.rx_valid && r.phase == 2'h1)) |=> result_ready_n;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("result-ready not cleared");

    property p_boot_low;
        (r.mode == M_BOOT) |-> !result_ready_n;
    endproperty
    a_boot_low: assert property (p_boot_low) else $error("result-ready high during reset");

    property p_no_data_nack;
        link.rd_hdr |-> (r.have && r.mode != M_TRIG && r.mode != M_BOOT);
    endproperty
    a_no_data_nack: assert property (p_no_data_nack) else $error("read allowed without data");

    c_cont: cover property (r.mode == M_CONT && tick);
    c_trig: cover property (r.mode == M_TRIG ##1 r.mode == M_IDLE);
    c_soft: cover property (soft_exec);
    c_read: cover property (link.rd_hdr ##1 result_ready_n);

endmodule // prs_sensor_top

// [prs_bus_master.sv]
/* Behavioural two-wire bus master that drives the sensor's serial port.
   Assumes the bench resolves the open-drain data wire with a pull-up. */
`timescale 1ns/100ps
module prs_bus_master (
    output logic scl, // serial clock, stands high between frames
    output logic sda_oe, // pulls the data wire low while high
    input wire logic sda // resolved data wire level
);
    initial {scl, sda_oe} = 2'b10;
    // The link period is kept at 48 ns to match the shortened timers.
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #12 sda_oe = ~b;
        #12 scl = 1'b1;
        r = sda;
        #24;
    endtask
    task automatic start;
        sda_oe = 1'b1;
        #24;
    endtask
    task automatic stop;
        scl = 1'b0;
        #12 sda_oe = 1'b1;
        #12 scl = 1'b1;
        #24 sda_oe = 1'b0;
        #24;
    endtask
    // Bytes go out MSB first; the ninth bit is our acknowledge on reads.
    task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(nak, r);
        ack = ~r;
    endtask
endmodule // prs_bus_master

// [test_pressure_sensor_ready_and_addressing.sv]
/* Self-checking bench for the sensor target: boot, strap, continuous,
   triggered and soft reset behaviour. Assumes prs_pkg and the bus master. */
`timescale 1ns/100ps
module test_pressure_sensor_ready_and_addressing;
    import prs_pkg::*;
    localparam int PU = 200;
    localparam int SR = 150;
    localparam int UP = 1000;
    localparam int TM = 300;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr_sel = 2'h0;
    logic [15:0] pres = 16'hA5C3;
    logic [15:0] temp = 16'h1E07;
    logic scl, m_oe, dut_oe, dut_do, rdy_n, sda;
    int now = 0;
    int miscompares = 0;
    int samples_checked = 0;
    assign sda = ~(dut_oe | m_oe);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) now++;
    prs_sensor_top #(.POWER_UP_CYC(PU), .SOFT_RESET_CYC(SR), .TRIG_MEAS_CYC(TM),
        .UPDATE_CYC(UP)) dut (.mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(dut_do),
        .sda_oe(dut_oe), .addr_sel(addr_sel), .pres_sample(pres), .temp_sample(temp),
        .result_ready_n(rdy_n));
    prs_bus_master m (.scl(scl), .sda_oe(m_oe), .sda(sda));
    task automatic close_out;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Bounded so that a ready pin that never falls cannot hang the run.
    task automatic wait_low;
        int k = 0;
        while (rdy_n !== 1'b0 && k < 2 * UP) begin
            cyc(1);
            k++;
        end
        if (k >= 2 * UP) begin
            miscompares++;
            $display("ERROR at %0t: ready pin %h expected %h", $time, rdy_n, 1'b0);
            close_out;
        end
    endtask
    function automatic logic [7:0] crc(input logic [15:0] w);
        logic [7:0] c = 8'hFF;
        for (int i = 15; i >= 0; i--)
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
        return c;
    endfunction
    task automatic hdr(input logic [6:0] a, input logic rd, output logic ack);
        logic [7:0] q;
        m.start();
        m.xfer({a, rd}, 1'b1, q, ack);
    endtask
    // A granted read must end with one byte and our refusal, or stop is blocked.
    task automatic probe(input logic [6:0] a, input logic rd, input logic exp);
        logic ack;
        logic [7:0] q;
        hdr(a, rd, ack);
        chk(ack, exp);
        if (rd && ack)
            m.xfer(8'hFF, 1'b1, q, ack);
        m.stop();
    endtask
    task automatic cmd(input logic [6:0] a, input logic [15:0] c);
        logic ack;
        logic [7:0] q;
        hdr(a, 1'b0, ack);
        m.xfer(c[15:8], 1'b1, q, ack);
        m.xfer(c[7:0], 1'b1, q, ack);
        m.stop();
    endtask
    task automatic do_reset(input logic [1:0] s);
        rst = 1'b1;
        addr_sel = s;
        cyc(5);
        rst = 1'b0;
        cyc(PU + 10);
    endtask
    task automatic t_addr;
        logic [6:0] a [3] = '{7'h21, 7'h22, 7'h23};
        for (int s = 0; s < 3; s++) begin
            do_reset(2'(s));
            probe(a[s], 1'b0, 1'b1);
            probe(a[(s + 1) % 3], 1'b0, 1'b0);
            addr_sel = 2'((s + 1) % 3);
            cyc(10);
            probe(a[s], 1'b0, 1'b1);
        end
        do_reset(2'h3);
        probe(7'h21, 1'b0, 1'b1);
        $display("address test done");
    endtask
    task automatic t_cont;
        logic [15:0] codes [4] = '{16'h3603, 16'h3608, 16'h3615, 16'h361E};
        logic [7:0] e [6];
        logic [7:0] q;
        logic ack;
        int t0;
        for (int i = 0; i < 4; i++) begin
            pres = pres + 16'h1357;
            temp = temp - 16'h0421;
            e = '{pres[15:8], pres[7:0], crc(pres), temp[15:8], temp[7:0], crc(temp)};
            do_reset(2'h0);
            cmd(7'h21, codes[i]);
            chk(rdy_n, 1'b1);
            probe(7'h21, 1'b1, 1'b0);
            wait_low;
            t0 = now;
            hdr(7'h21, 1'b1, ack);
            chk(ack, 1'b1);
            chk(rdy_n, 1'b1);
            for (int j = 0; j < 6; j++) begin
                m.xfer(8'hFF, j == 5, q, ack);
                chk(q, e[j]);
            end
            m.stop();
            wait_low;
            chk(now - t0, UP);
        end
        probe(7'h21, 1'b1, 1'b1);
        cmd(7'h21, 16'h3FF9);
        cyc(2 * UP);
        chk(rdy_n, 1'b1);
        $display("continuous test done");
    endtask
    task automatic t_trig_soft;
        int t0;
        do_reset(2'h0);
        cmd(7'h21, 16'h3624);
        t0 = now;
        probe(7'h21, 1'b1, 1'b0);
        wait_low;
        chk(now - t0 <= TM, 1'b1);
        probe(7'h21, 1'b1, 1'b1);
        cmd(7'h21, 16'h0006);
        chk(rdy_n, 1'b0);
        probe(7'h21, 1'b0, 1'b0);
        cyc(SR);
        probe(7'h21, 1'b0, 1'b1);
        $display("triggered and soft reset test done");
    endtask
    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(2);
        chk(rdy_n, 1'b0);
        chk(dut_do, 1'b0);
        probe(7'h21, 1'b0, 1'b0);
        cyc(PU);
        probe(7'h21, 1'b0, 1'b1);
        $display("boot test done");
        t_addr;
        t_cont;
        t_trig_soft;
        close_out;
    end
endmodule // test_pressure_sensor_ready_and_addressing
